/* rtl/jtp_defs.svh */
`ifndef JTP_DEFS_SVH
`define JTP_DEFS_SVH

// Instruction register width and codes
`define JTP_IR_W        4
`define JTP_INSTR_IDCODE 4'h1
`define JTP_INSTR_BYPASS 4'hF

// Value loaded into the instruction shifter in the capture state (low bits 01)
`define JTP_IR_CAPTURE  4'h1

// Identification register width and value (value is arbitrary, not a real part code)
`define JTP_ID_W        32
`define JTP_IDCODE_VAL  32'h1234_5671

// Depth of the pin synchronisers
`define JTP_SYNC_STAGES 2

// Consecutive mode-select-high edges that always reach test-logic-reset
`define JTP_TLR_ONES    3'h5

`endif

/* rtl/jtp_pkg.sv */
package jtp_pkg;

	// Sixteen controller states, one-hot
	typedef enum logic [15:0] {
		ST_TLR    = 16'h0001,
		ST_RTI    = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHF_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHF_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} jtp_state_t;

endpackage

/* rtl/jtp_shift_reg.sv */
`timescale 1ns/1ps
`default_nettype none

// Capture/shift register; shifts toward bit 0, new bit enters at the top
module jtp_shift_reg #(
	parameter int W = 4                   // Register length, at least 2
) (
	input  wire logic         clk,        // System clock
	input  wire logic         rst_b,      // Synchronous reset, active low
	input  wire logic         clear,      // Synchronous clear (test reset)
	input  wire logic         capture,    // Parallel load this cycle
	input  wire logic [W-1:0] cap_val,    // Parallel load value
	input  wire logic         shift,      // Shift one place this cycle
	input  wire logic         sin,        // Serial input bit
	output logic      [W-1:0] data        // Register contents
);

	logic [W-1:0] sh_reg;                 // Shift stage
	logic [W-1:0] sh_next;                // Its next value

	// Capture wins over shift; both only ever come on a test clock rise
	assign sh_next = capture ? cap_val :
	                 shift   ? {sin, sh_reg[W-1:1]} : sh_reg;

	// Storage
	always_ff @(posedge clk) begin
		if (!rst_b || clear) begin
			sh_reg <= '0;
		end else begin
			sh_reg <= sh_next;
		end
	end

	assign data = sh_reg;

endmodule

`default_nettype wire

/* rtl/jtp_tap.sv */
// Functional notes
// - All port logic except test reset timed by test clock edges
// - Data input captured on rising test clock
// - Mode select sampled on rise, steers controller
// - Data output driven only in shift states
// - Data output changes only on falling edges and on test reset
// - Test reset initialises controller without clock edge
`timescale 1ns/1ps
`default_nettype none
`include "jtp_defs.svh"

module jtp_tap #(
	parameter int IR_W = `JTP_IR_W,                       // Instruction length
	parameter int ID_W = `JTP_ID_W,                       // Identification length
	parameter logic [`JTP_ID_W-1:0] IDCODE = `JTP_IDCODE_VAL // Arbitrary id value
) (
	input  wire logic              clk,        // System clock, 200 MHz
	input  wire logic              rst_b,      // Synchronous reset, active low
	input  wire logic              tck,        // Test clock pin
	input  wire logic              tms,        // Test mode select pin
	input  wire logic              tdi,        // Test data input pin
	input  wire logic              trst_b,     // Test reset pin, active low
	output logic                   tdo,        // Test data output value
	output logic                   tdo_oe,     // Test data output enable
	output jtp_pkg::jtp_state_t    tap_state,  // Controller state
	output logic [IR_W-1:0]        ir_value    // Active instruction
);

	// Pin synchronisers; stage 1 is read only by stage 2
	logic tck_s1, tck_s2, tck_s3;              // Test clock stages, s3 for edges
	logic tms_s1, tms_s2;                      // Mode select stages
	logic tdi_s1, tdi_s2;                      // Data input stages
	logic trst_s1, trst_s2;                    // Test reset stages (low = reset)

	jtp_pkg::jtp_state_t state_reg;            // Controller state
	jtp_pkg::jtp_state_t state_next;           // Its next value
	logic [IR_W-1:0]     ir_reg;               // Active instruction
	logic                bypass_reg;           // One-bit bypass stage
	logic                tdo_reg;              // Output data flop
	logic                oe_reg;               // Output enable flop
	logic [IR_W-1:0]     ir_sh;                // Instruction shifter contents
	logic [ID_W-1:0]     id_sh;                // Identification shifter contents

	// Edge finding on the sampled test clock
	wire tck_rise  = tck_s2 & ~tck_s3;
	wire tck_fall  = ~tck_s2 & tck_s3;
	wire test_rst  = ~trst_s2;
	wire in_shf_dr = (state_reg == jtp_pkg::ST_SHF_DR);
	wire in_shf_ir = (state_reg == jtp_pkg::ST_SHF_IR);
	wire in_shift  = in_shf_dr | in_shf_ir;
	wire nx_shift  = (state_next == jtp_pkg::ST_SHF_DR) || (state_next == jtp_pkg::ST_SHF_IR);
	wire sel_id    = (ir_reg == IR_W'(`JTP_INSTR_IDCODE));
	wire dr_bit    = sel_id ? id_sh[0] : bypass_reg;
	wire out_bit   = in_shf_ir ? ir_sh[0] : dr_bit;
	wire ir_cap    = tck_rise & (state_reg == jtp_pkg::ST_CAP_IR);
	wire ir_shf    = tck_rise & in_shf_ir;
	wire id_cap    = tck_rise & sel_id & (state_reg == jtp_pkg::ST_CAP_DR);
	wire id_shf    = tck_rise & sel_id & in_shf_dr;

	// Two-flop synchronisers; the pins belong to the tester's timing
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{tck_s1, tck_s2, tck_s3} <= 3'h0;
			{tms_s1, tms_s2}         <= 2'h3;
			{tdi_s1, tdi_s2}         <= 2'h3;
			{trst_s1, trst_s2}       <= 2'h0;
		end else begin
			{tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
			{tms_s1, tms_s2}         <= {tms, tms_s1};
			{tdi_s1, tdi_s2}         <= {tdi, tdi_s1};
			{trst_s1, trst_s2}       <= {trst_b, trst_s1};
		end
	end

	// Standard controller transitions, steered by mode select
	always_comb begin
		case (state_reg)
			jtp_pkg::ST_TLR:    state_next = tms_s2 ? jtp_pkg::ST_TLR    : jtp_pkg::ST_RTI;
			jtp_pkg::ST_RTI:    state_next = tms_s2 ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			jtp_pkg::ST_SEL_DR: state_next = tms_s2 ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: state_next = tms_s2 ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_SHF_DR: state_next = tms_s2 ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_EX1_DR: state_next = tms_s2 ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_PAU_DR: state_next = tms_s2 ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_EX2_DR: state_next = tms_s2 ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_UPD_DR: state_next = tms_s2 ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			jtp_pkg::ST_SEL_IR: state_next = tms_s2 ? jtp_pkg::ST_TLR    : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: state_next = tms_s2 ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_SHF_IR: state_next = tms_s2 ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_EX1_IR: state_next = tms_s2 ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_PAU_IR: state_next = tms_s2 ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_EX2_IR: state_next = tms_s2 ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_UPD_IR: state_next = tms_s2 ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
			default:            state_next = jtp_pkg::ST_TLR;  // Illegal code recovers
		endcase
	end

	// Controller state: test reset overrides, otherwise moves on test clock rise
	always_ff @(posedge clk) begin
		if (!rst_b || test_rst) begin
			state_reg <= jtp_pkg::ST_TLR;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	// Active instruction: identification after reset, new code on update
	always_ff @(posedge clk) begin
		if (!rst_b || test_rst || state_reg == jtp_pkg::ST_TLR) begin
			ir_reg <= IR_W'(`JTP_INSTR_IDCODE);
		end else if (tck_rise && state_reg == jtp_pkg::ST_UPD_IR) begin
			ir_reg <= ir_sh;
		end
	end

	// Bypass stage: zero on capture, takes the data input while shifting
	always_ff @(posedge clk) begin
		if (!rst_b || test_rst) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && !sel_id && state_reg == jtp_pkg::ST_CAP_DR) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && !sel_id && in_shf_dr) begin
			bypass_reg <= tdi_s2;
		end
	end

	// Output data moves only on a falling test clock edge in a shift state, or clears to zero on test reset
	always_ff @(posedge clk) begin
		if (!rst_b || test_rst) begin
			tdo_reg <= 1'b0;
		end else if (tck_fall && in_shift) begin
			tdo_reg <= out_bit;
		end
	end

	// Enable rises at the first fall inside a shift state and drops on the
	// very rise that leaves it, so the pin is never driven outside shifting
	always_ff @(posedge clk) begin
		if (!rst_b || test_rst) begin
			oe_reg <= 1'b0;
		end else if (tck_rise && !nx_shift) begin
			oe_reg <= 1'b0;
		end else if (tck_fall && in_shift) begin
			oe_reg <= 1'b1;
		end
	end

	// Instruction shifter
	jtp_shift_reg #(.W(IR_W)) u_ir_sh (
		.clk     (clk),
		.rst_b   (rst_b),
		.clear   (test_rst),
		.capture (ir_cap),
		.cap_val (IR_W'(`JTP_IR_CAPTURE)),
		.shift   (ir_shf),
		.sin     (tdi_s2),
		.data    (ir_sh)
	);

	// Identification shifter
	jtp_shift_reg #(.W(ID_W)) u_id_sh (
		.clk     (clk),
		.rst_b   (rst_b),
		.clear   (test_rst),
		.capture (id_cap),
		.cap_val (IDCODE),
		.shift   (id_shf),
		.sin     (tdi_s2),
		.data    (id_sh)
	);

	assign tdo       = tdo_reg;
	assign tdo_oe    = oe_reg;
	assign tap_state = state_reg;
	assign ir_value  = ir_reg;

	// Checking helper: rising edges seen in a row with mode select high
	logic [2:0] ones_cnt;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ones_cnt <= 3'h0;
		end else if (tck_rise) begin
			ones_cnt <= !tms_s2 ? 3'h0 :
			            (ones_cnt == `JTP_TLR_ONES) ? ones_cnt : ones_cnt + 3'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence seq_fall_in_shift;
		tck_fall && in_shift && trst_s2;
	endsequence

	sequence seq_leave_shift;
		tck_rise && in_shift && !nx_shift;
	endsequence

	AST_STATE_ON_RISE: assert property (
		!$stable(state_reg) |-> $past(tck_rise) || $past(test_rst))
		else $error("State moved without a test clock rise or test reset");

	AST_TDI_INTO_BYPASS: assert property (
		(tck_rise && in_shf_dr && !sel_id && trst_s2) |=> bypass_reg == $past(tdi_s2))
		else $error("Bypass stage did not take the data input");

	AST_TMS_STEERS: assert property (
		(tck_rise && state_reg == jtp_pkg::ST_RTI && trst_s2) |=>
		(state_reg == ($past(tms_s2) ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI)))
		else $error("Mode select did not steer the controller");

	AST_OE_ONLY_SHIFT: assert property (
		tdo_oe |-> in_shift)
		else $error("Data output driven outside a shift state");

	AST_OE_ON_SHIFT: assert property (
		seq_fall_in_shift |=> tdo_oe)
		else $error("Data output not enabled in a shift state");

	AST_OE_DROP: assert property (
		seq_leave_shift |=> !tdo_oe ##1 !tdo_oe)
		else $error("Data output still driven after leaving shift");

	AST_TDO_ON_FALL: assert property (
		!$stable(tdo) |-> $past(tck_fall) || $past(test_rst))
		else $error("Data output changed away from a falling edge");

	AST_TRST_INIT: assert property (
		test_rst |=> state_reg == jtp_pkg::ST_TLR && !tdo_oe)
		else $error("Test reset did not initialise the controller");

	AST_FIVE_ONES: assert property (
		(ones_cnt == `JTP_TLR_ONES) |-> state_reg == jtp_pkg::ST_TLR)
		else $error("Five mode select ones did not reach reset");

endmodule

`default_nettype wire

/* sim/jtp_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Test controller model; its clock rests low between bits
module jtp_host (
	output logic      tck,     // Test clock pin
	output logic      tms,     // Mode select pin
	output logic      tdi,     // Data input pin
	output logic      trst_b,  // Test reset pin, active low
	input  wire logic tdo_pin  // Resolved data output wire
);
	// Power-up: test reset held low until the bench lets it go
	initial begin
		tck    = 1'b0;
		tms    = 1'b1;
		tdi    = 1'b1;
		trst_b = 1'b0;
	end

	// One bit: values set at the fall, held across the rise, output taken before it
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80.0;
		o   = tdo_pin;
		tck = 1'b1;
		#80.0;
		tck = 1'b0;
	endtask

	// Test reset pulse with the test clock standing still
	task automatic reset_pulse(input int ns);
		trst_b = 1'b0;
		#(ns);
		trst_b = 1'b1;
	endtask
endmodule

`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jtp_defs.svh"

module testbench;
	typedef struct packed {
		logic                m;   // Mode select for the step
		jtp_pkg::jtp_state_t st;  // State after the rise
		logic                oe;  // Output enable seen at the rise
	} jtp_row_t;

	logic                clk;          // System clock
	logic                rst_b;        // Synchronous reset
	logic                oe_rise;      // Output enable at each test clock rise
	logic                tdo;          // Data output value
	logic                tdo_oe;       // Data output enable
	logic                tdo_pin;      // Resolved data output wire
	logic [3:0]          ir_value;     // Active instruction
	logic [31:0]         v;            // Shifted-out bits
	jtp_pkg::jtp_state_t tap_state;    // Controller state
	wire                 tck;          // Test clock
	wire                 tms;          // Mode select
	wire                 tdi;          // Data input
	wire                 trst_b;       // Test reset
	int                  error_cnt = 0;   // Mismatches
	int                  check_count = 0; // Comparisons

	// Every state at least once, starting from test-logic-reset
	jtp_row_t rows [17] = '{
		'{1'b0, jtp_pkg::ST_RTI, 1'b0}, '{1'b1, jtp_pkg::ST_SEL_DR, 1'b0},
		'{1'b0, jtp_pkg::ST_CAP_DR, 1'b0}, '{1'b0, jtp_pkg::ST_SHF_DR, 1'b0},
		'{1'b1, jtp_pkg::ST_EX1_DR, 1'b1}, '{1'b0, jtp_pkg::ST_PAU_DR, 1'b0},
		'{1'b1, jtp_pkg::ST_EX2_DR, 1'b0}, '{1'b1, jtp_pkg::ST_UPD_DR, 1'b0},
		'{1'b1, jtp_pkg::ST_SEL_DR, 1'b0}, '{1'b1, jtp_pkg::ST_SEL_IR, 1'b0},
		'{1'b0, jtp_pkg::ST_CAP_IR, 1'b0}, '{1'b0, jtp_pkg::ST_SHF_IR, 1'b0},
		'{1'b1, jtp_pkg::ST_EX1_IR, 1'b1}, '{1'b0, jtp_pkg::ST_PAU_IR, 1'b0},
		'{1'b1, jtp_pkg::ST_EX2_IR, 1'b0}, '{1'b1, jtp_pkg::ST_UPD_IR, 1'b0},
		'{1'b0, jtp_pkg::ST_RTI, 1'b0}};

	jtp_tap jtp_tap_inst (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_b(trst_b), .tdo(tdo), .tdo_oe(tdo_oe), .tap_state(tap_state),
		.ir_value(ir_value));
	jtp_host jtp_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
		.tdo_pin(tdo_pin));

	// Released wire shows the inverse of the last bit, so a missing enable never passes
	assign tdo_pin = tdo_oe ? tdo : ~tdo;

	// System clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Enable taken at each test clock rise
	always @(posedge tck) oe_rise = tdo_oe;

	// Data output may only move while the test clock is low
	always @(tdo) chk_val(tck, 0);

	// Enable only in the two shift states
	always @(negedge clk) begin
		if (tdo_oe === 1'b1) begin
			chk_val(tap_state === jtp_pkg::ST_SHF_DR || tap_state === jtp_pkg::ST_SHF_IR, 1);
		end
	end

	// Compare a value; unknown bits never match
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compare a controller state
	task automatic chk_st(input jtp_pkg::jtp_state_t got, input jtp_pkg::jtp_state_t exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t ns: state %h expected %h", $time, got, exp);
		end
	endtask

	// Walk n mode-select bits, oldest first, data input high
	task automatic go(input logic [7:0] seq, input int n);
		logic b;
		for (int i = 0; i < n; i++) begin
			jtp_host_inst.step(seq[i], 1'b1, b);
		end
	endtask

	// Shift n bits, leaving the shift state on the last one
	task automatic shf(input int n, output logic [31:0] r);
		logic b;
		r = '0;
		for (int k = 0; k < n; k++) begin
			jtp_host_inst.step(k == n - 1, 1'b1, b);
			r[k] = b;
		end
	endtask

	// Verdict
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog: about twenty-four times the expected run
	initial begin
		#300000;
		error_cnt++;
		end_of_test();
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (10) @(negedge clk);
		chk_st(tap_state, jtp_pkg::ST_TLR);
		chk_val(ir_value, `JTP_INSTR_IDCODE);
		chk_val({tdo, tdo_oe}, 0);
		rst_b = 1'b1;
		jtp_host_inst.reset_pulse(40);
		#53.3;
		foreach (rows[i]) begin
			jtp_host_inst.step(rows[i].m, 1'b1, v[0]);
			chk_st(tap_state, rows[i].st);
			chk_val(oe_rise, rows[i].oe);
		end
		// Bypass captures zero, then five ones from a shift state
		go(8'h01, 3);
		shf(1, v);
		chk_val(v, 0);
		chk_val(oe_rise, 1);
		go(8'h0F, 4);
		chk_st(tap_state, jtp_pkg::ST_TLR);
		chk_val(ir_value, `JTP_INSTR_IDCODE);
		// Identification read, least significant bit first
		go(8'h02, 4);
		shf(32, v);
		chk_val(v, `JTP_IDCODE_VAL);
		// Instruction capture, then load bypass
		go(8'h07, 5);
		shf(4, v);
		chk_val(v, `JTP_IR_CAPTURE);
		// The new code takes effect on the rise that leaves the update state
		go(8'h01, 2);
		chk_st(tap_state, jtp_pkg::ST_RTI);
		chk_val(ir_value, `JTP_INSTR_BYPASS);
		// Test reset in mid-shift with the test clock still
		go(8'h02, 4);
		#30;
		chk_val(tdo_oe, 1);
		jtp_host_inst.reset_pulse(40);
		#20;
		chk_st(tap_state, jtp_pkg::ST_TLR);
		chk_val({tdo_oe, ir_value}, {1'b0, `JTP_INSTR_IDCODE});
		end_of_test();
	end
endmodule

`default_nettype wire
